/* File: logic/rtr_params.svh */
// rtr_params.svh - offsets, field positions, reset values and counts
// of the touch result register block.
// assumes: included by bare name from the design files and the checker.
`ifndef RTR_PARAMS_SVH
`define RTR_PARAMS_SVH

// register byte offsets on the 32-bit bus
`define RTR_OFF_PRESSURE     12'h120
`define RTR_OFF_SCREEN_XY    12'h124
`define RTR_OFF_TAG_XY       12'h128
`define RTR_OFF_TAG          12'h12C
`define RTR_OFF_DIRECT_XY    12'h18C
`define RTR_OFF_RAW_Z        12'h190
`define RTR_OFF_INT_STATUS   12'h200
`define RTR_OFF_INT_ENABLE   12'h204
`define RTR_OFF_INT_CLEAR    12'h208
`define RTR_ADDR_W           12

// field positions
`define RTR_HI_LSB           16
`define RTR_NOTOUCH_BIT      31
`define RTR_SAMPLE_W         10
`define RTR_COORD_W          16
`define RTR_TAG_W            8
`define RTR_PRESS_W          16
`define RTR_INT_W            4
`define RTR_INT_TOUCH        0
`define RTR_INT_RELEASE      1
`define RTR_INT_TAG          2
`define RTR_INT_SAMPLE       3

// reset values and codes
`define RTR_RST_SCREEN_XY    32'h80008000
`define RTR_NOTOUCH_COORD    16'h8000
`define RTR_RST_TAG_XY       32'h00000000
`define RTR_RST_DIRECT_XY    32'h00000000
`define RTR_RST_RAW_Z        32'h00000000
`define RTR_RST_TAG          8'h00
`define RTR_PRESS_NOTOUCH    16'h7FFF
`define RTR_PRESS_SHIFT      5

`endif

/* File: logic/rtr_pkg.sv */
// rtr_pkg.sv - types shared by the touch result register block.
// assumes: constants come from rtr_params.svh, not from here.
package rtr_pkg;
    typedef enum logic [1:0]
    {
        RTR_RESP_OKAY   = 2'h0,
        RTR_RESP_SLVERR = 2'h2
    } rtr_resp_t;

    typedef logic [15:0] rtr_coord_t;
    typedef logic [9:0]  rtr_sample_t;
endpackage : rtr_pkg

/* File: logic/rtr_pressure.sv */
// rtr_pressure.sv - derives the pressure figure from the two
// resistance samples.
// assumes: sample_valid is a one-cycle pulse on aclk with stable data.
`timescale 1ns/1ns
`include "rtr_params.svh"

module rtr_pressure
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               sample_valid,
    input  wire logic               touch_sensed,
    input  wire rtr_pkg::rtr_sample_t first_sample,
    input  wire rtr_pkg::rtr_sample_t second_sample,
    output logic [15:0]             pressure
);
    // saturating difference; a crossed pair means no measurable spread
    function automatic logic [9:0] rtr_sat_diff
    (
        input logic [9:0] a,
        input logic [9:0] b
    );
        rtr_sat_diff = (a > b) ? (a - b) : 10'h000;
    endfunction : rtr_sat_diff

    wire logic [9:0]  spread = rtr_sat_diff(second_sample, first_sample);
    // 1023 << 5 stays below the no-touch code, so it never aliases it
    wire logic [15:0] scaled = {1'b0, spread, 5'h00};
    wire logic [15:0] next_pressure =
        touch_sensed ? scaled : `RTR_PRESS_NOTOUCH;

    // result moves only with a fresh sample pair
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pressure <= `RTR_PRESS_NOTOUCH;
        else if (sample_valid)
            pressure <= next_pressure;
    end
endmodule : rtr_pressure

/* File: logic/rtr_result_regs.sv */
// rtr_result_regs.sv - result registers of the resistive touch engine,
// reachable over AXI4-Lite, with a sticky interrupt status.
// assumes: sample and frame inputs come from logic on aclk, so they
// are read without synchronisers; sample_valid and frame_done are
// one-cycle pulses.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "rtr_params.svh"

// Behaviour
// RULE1 - tag lookup coords: X high, Y low
// RULE2 - tag coords match last tag update
// RULE3 - calibrated screen X high, Y low
// RULE4 - no touch reads 0x8000 per half
// RULE5 - raw resistance samples in two fields
// RULE6 - pressure derived from resistance samples
// RULE7 - software checks direct flag for touch
// RULE8 - direct flag zero while touch sensed
// RULE9 - software ignores fields when flag set
// RULE10 - direct fields 10-bit, reserved read zero
// RULE11 - tag refreshed once per frame end
// RULE12 - tag 1..255 object, zero no touch
// RULE13 - pressure reads 0x7FFF without touch
// RULE14 - writes to result registers are ignored
module rtr_result_regs
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // sample side, from the ADC sequencer on aclk
    input  wire logic                 sample_valid,
    input  wire logic                 touch_sensed,
    input  wire rtr_pkg::rtr_sample_t direct_x,
    input  wire rtr_pkg::rtr_sample_t direct_y,
    input  wire rtr_pkg::rtr_sample_t first_resistance_sample,
    input  wire rtr_pkg::rtr_sample_t second_resistance_sample,
    input  wire rtr_pkg::rtr_coord_t  calibrated_x,
    input  wire rtr_pkg::rtr_coord_t  calibrated_y,
    // tag lookup, from the display scan-out
    input  wire logic                 frame_done,
    input  wire logic [7:0]           tag_result,
    output rtr_pkg::rtr_coord_t       tag_query_x,
    output rtr_pkg::rtr_coord_t       tag_query_y,
    // interrupt
    output logic                      irq
);
    // ---------------- result state ----------------
    logic [31:0] calibrated_screen_coords;
    logic [31:0] tag_lookup_coords;
    logic [31:0] direct_sample_with_flag;
    logic [31:0] raw_resistance_samples;
    logic [7:0]  touch_tag;
    logic [15:0] touch_pressure_value;
    logic        touch_held;

    // ---------------- interrupt state ----------------
    logic [3:0]  int_status;
    logic [3:0]  int_enable;

    // ---------------- bus state ----------------
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // word address of a byte address; the low two bits pick a byte
    // lane, and every register here is one whole aligned word
    function automatic logic [11:0] rtr_word_addr
    (
        input logic [11:0] byte_addr
    );
        rtr_word_addr = {byte_addr[11:2], 2'h0};
    endfunction : rtr_word_addr

    // unmapped words answer with a slave error, mapped ones okay
    function automatic rtr_pkg::rtr_resp_t rtr_resp_for
    (
        input logic mapped
    );
        rtr_resp_for = mapped ? rtr_pkg::RTR_RESP_OKAY
                              : rtr_pkg::RTR_RESP_SLVERR;
    endfunction : rtr_resp_for

    // ---------------- sample path ----------------
    // calibrated pair, or the no-touch code in both halves
    wire logic [31:0] next_screen =
        touch_sensed ? {calibrated_x, calibrated_y}
                     : {`RTR_NOTOUCH_COORD, `RTR_NOTOUCH_COORD};

    // fields only meaningful with the flag low; reserved bits stay zero
    wire logic [31:0] next_direct =
        {~touch_sensed, 5'h00, direct_x, 6'h00, direct_y};

    wire logic [31:0] next_raw_z =
        {6'h00, first_resistance_sample,
         6'h00, second_resistance_sample};

    // touch results move only on a fresh sample pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            calibrated_screen_coords <= `RTR_RST_SCREEN_XY;   // [RULE4]
            direct_sample_with_flag  <= `RTR_RST_DIRECT_XY;
            raw_resistance_samples   <= `RTR_RST_RAW_Z;
            touch_held               <= 1'b0;
        end
        else if (sample_valid)
        begin
            calibrated_screen_coords <= next_screen;   // [RULE3] [RULE4]
            direct_sample_with_flag  <= next_direct;   // [RULE8] [RULE10]
            raw_resistance_samples   <= next_raw_z;    // [RULE5]
            touch_held               <= touch_sensed;
        end
    end

    // pressure post-processing of the two resistance samples
    rtr_pressure u_pressure
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .sample_valid  (sample_valid),                 // [RULE6]
        .touch_sensed  (touch_sensed),                 // [RULE13]
        .first_sample  (first_resistance_sample),
        .second_sample (second_resistance_sample),
        .pressure      (touch_pressure_value)
    );

    // ---------------- tag lookup ----------------
    // the scan-out looks up the tag at the current screen point
    assign tag_query_x =
        calibrated_screen_coords[31:`RTR_HI_LSB];
    assign tag_query_y =
        calibrated_screen_coords[`RTR_COORD_W-1:0];

    // no touch forces tag zero whatever the lookup returned
    wire logic [7:0] next_tag = touch_held ? tag_result : `RTR_RST_TAG;

    // coords latched in the same edge as the tag, so software can
    // always match a tag to the point that produced it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            touch_tag         <= `RTR_RST_TAG;        // [RULE12]
            tag_lookup_coords <= `RTR_RST_TAG_XY;     // [RULE1]
        end
        else if (frame_done)                          // [RULE11]
        begin
            touch_tag         <= next_tag;            // [RULE12]
            tag_lookup_coords <= {tag_query_x,
                                  tag_query_y};       // [RULE1] [RULE2]
        end
    end

    // ---------------- interrupt events ----------------
    wire logic ev_touch   = sample_valid & touch_sensed & ~touch_held;
    wire logic ev_release = sample_valid & ~touch_sensed & touch_held;
    wire logic ev_tag     = frame_done & (next_tag != touch_tag);
    wire logic ev_sample  = sample_valid;

    wire logic [3:0] int_events =
        {ev_sample, ev_tag, ev_release, ev_touch};

    // ---------------- AXI4-Lite write path ----------------
    // address and data are taken independently and held until both
    // are present; the response waits for bready before new ones
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held  & ~s_axi_bvalid;

    wire logic aw_take  = s_axi_awvalid & s_axi_awready;
    wire logic w_take   = s_axi_wvalid  & s_axi_wready;
    wire logic wr_fire  = aw_held & w_held & ~s_axi_bvalid;

    wire logic [11:0] wr_word = rtr_word_addr(aw_addr);

    // result registers accept the write and keep their value
    wire logic wr_is_ro =
        (wr_word == `RTR_OFF_PRESSURE)   |
        (wr_word == `RTR_OFF_SCREEN_XY)  |
        (wr_word == `RTR_OFF_TAG_XY)     |
        (wr_word == `RTR_OFF_TAG)        |
        (wr_word == `RTR_OFF_DIRECT_XY)  |
        (wr_word == `RTR_OFF_RAW_Z)      |
        (wr_word == `RTR_OFF_INT_STATUS);
    wire logic wr_enable = wr_word == `RTR_OFF_INT_ENABLE;
    wire logic wr_clear  = wr_word == `RTR_OFF_INT_CLEAR;
    wire logic wr_mapped = wr_is_ro | wr_enable | wr_clear;

    // only the low byte lane carries interrupt bits
    wire logic       lane0    = w_strb[0];
    wire logic [3:0] wr_bits  = w_data[`RTR_INT_W-1:0];
    wire logic [3:0] clr_bits =
        (wr_fire & wr_clear & lane0) ? wr_bits : 4'h0;

    wire rtr_pkg::rtr_resp_t wr_resp = rtr_resp_for(wr_mapped);

    // hold registers for the two halves of a write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 12'h000;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held <= 1'b0;
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held <= 1'b0;
        end
    end

    // write response, raised one edge after both halves are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_resp;                  // [RULE14]
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ---------------- interrupt registers ----------------
    // a new event beats a clear in the same cycle
    wire logic [3:0] next_status = (int_status & ~clr_bits) | int_events;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            int_status <= 4'h0;
            int_enable <= 4'h0;
        end
        else
        begin
            int_status <= next_status;
            if (wr_fire & wr_enable & lane0)
                int_enable <= wr_bits;
        end
    end

    assign irq = |(int_status & int_enable);

    // ---------------- AXI4-Lite read path ----------------
    assign s_axi_arready = ~s_axi_rvalid;

    wire logic       ar_take = s_axi_arvalid & s_axi_arready;
    wire logic [11:0] rd_word = rtr_word_addr(s_axi_araddr);

    wire logic rd_press  = rd_word == `RTR_OFF_PRESSURE;
    wire logic rd_screen = rd_word == `RTR_OFF_SCREEN_XY;
    wire logic rd_tagxy  = rd_word == `RTR_OFF_TAG_XY;
    wire logic rd_tag    = rd_word == `RTR_OFF_TAG;
    wire logic rd_direct = rd_word == `RTR_OFF_DIRECT_XY;
    wire logic rd_raw    = rd_word == `RTR_OFF_RAW_Z;
    wire logic rd_stat   = rd_word == `RTR_OFF_INT_STATUS;
    wire logic rd_en     = rd_word == `RTR_OFF_INT_ENABLE;
    wire logic rd_clr    = rd_word == `RTR_OFF_INT_CLEAR;

    wire logic rd_mapped = rd_press | rd_screen | rd_tagxy | rd_tag |
                           rd_direct | rd_raw | rd_stat | rd_en |
                           rd_clr;

    // one-hot select; reserved bits and the clear register read zero
    wire logic [31:0] rd_value =
        ({32{rd_press}}  & {16'h0000, touch_pressure_value}) |
        ({32{rd_screen}} & calibrated_screen_coords)         |
        ({32{rd_tagxy}}  & tag_lookup_coords)                |
        ({32{rd_tag}}    & {24'h000000, touch_tag})          |
        ({32{rd_direct}} & direct_sample_with_flag)          |
        ({32{rd_raw}}    & raw_resistance_samples)           |
        ({32{rd_stat}}   & {28'h0000000, int_status})        |
        ({32{rd_en}}     & {28'h0000000, int_enable});

    wire rtr_pkg::rtr_resp_t rd_resp = rtr_resp_for(rd_mapped);

    // read data captured at the address edge and held until taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_resp;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // prot bits carry no meaning for these registers
    wire logic unused_prot = ^{s_axi_awprot, s_axi_arprot, w_strb[3:1],
                               w_data[31:4], aw_addr[1:0]};

    // the direct flag alone tells software whether fields are valid;
    // the raw resistance word has no flag of its own  [RULE7] [RULE9]
endmodule : rtr_result_regs

/* File: test/rtr_result_regs_sva.sv */
// rtr_result_regs_sva.sv - bus and coordinate checks on the result regs
// assumes: bound into rtr_result_regs, single aclk domain.
`timescale 1ns/1ns
`include "rtr_params.svh"
module rtr_result_regs_sva
(
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic                 sample_valid,
    input wire logic                 touch_sensed,
    input wire rtr_pkg::rtr_coord_t  calibrated_x,
    input wire rtr_pkg::rtr_coord_t  calibrated_y,
    input wire logic                 frame_done,
    input wire rtr_pkg::rtr_coord_t  tag_query_x,
    input wire rtr_pkg::rtr_coord_t  tag_query_y
);
    // everything lives on aclk, reset masks all attempts
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // bus handshake timing
    chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not the inverse of rvalid");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    chk_aw_block: assert property (s_axi_awvalid && s_axi_awready
        |=> !s_axi_awready) else $error("second write address taken");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer missing");

    // lookup coordinates follow the calibrated screen register
    chk_tq_notouch: assert property (sample_valid && !touch_sensed
        |=> tag_query_x == `RTR_NOTOUCH_COORD
            && tag_query_y == `RTR_NOTOUCH_COORD)
        else $error("no touch code missing");
    chk_tq_touch: assert property (sample_valid && touch_sensed |=>
        tag_query_x == $past(calibrated_x)
            && tag_query_y == $past(calibrated_y))
        else $error("screen coordinates wrong");
    chk_tq_hold: assert property (!sample_valid |=>
        $stable(tag_query_x) && $stable(tag_query_y))
        else $error("screen coordinates moved without a sample");

    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (sample_valid && touch_sensed);
    cover property (frame_done);
endmodule : rtr_result_regs_sva

bind rtr_result_regs rtr_result_regs_sva u_sva (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .sample_valid, .touch_sensed, .calibrated_x, .calibrated_y,
    .frame_done, .tag_query_x, .tag_query_y);

/* File: test/rtr_panel_model.sv */
// rtr_panel_model.sv - panel plus ADC sequencer delivering sample sets
// assumes: go is a one-cycle request from the bench on aclk.
`timescale 1ns/1ns
module rtr_panel_model
(
    input  wire logic           aclk,
    input  wire logic           go,
    input  wire logic [72:0]    set_in,
    output logic                sample_valid,
    output logic                touch_sensed,
    output rtr_pkg::rtr_sample_t direct_x,
    output rtr_pkg::rtr_sample_t direct_y,
    output rtr_pkg::rtr_sample_t first_resistance_sample,
    output rtr_pkg::rtr_sample_t second_resistance_sample,
    output rtr_pkg::rtr_coord_t  calibrated_x,
    output rtr_pkg::rtr_coord_t  calibrated_y
);
    initial {sample_valid, touch_sensed, direct_x, direct_y,
        first_resistance_sample, second_resistance_sample,
        calibrated_x, calibrated_y} = 74'h0;

    // data churns between sets so a late read of the inputs shows up
    always @(posedge aclk)
    begin
        sample_valid <= go;
        if (go)
            {touch_sensed, direct_x, direct_y, first_resistance_sample,
             second_resistance_sample, calibrated_x, calibrated_y} <= set_in;
        else
            {direct_x, direct_y, first_resistance_sample,
             second_resistance_sample, calibrated_x, calibrated_y} <=
            ~{direct_x, direct_y, first_resistance_sample,
             second_resistance_sample, calibrated_x, calibrated_y};
    end
endmodule : rtr_panel_model

/* File: test/testbench.sv */
// testbench.sv - drives the result registers over AXI4-Lite
// assumes: panel model in rtr_panel_model.sv, checker bound separately.
`timescale 1ns/1ns
module testbench;
    logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, frame_done = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [7:0]  tag_result = 8'h00, tg;
    logic [72:0] set_in = 73'h0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic   s_axi_rvalid, irq, sample_valid, touch_sensed;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire rtr_pkg::rtr_coord_t  tag_query_x, tag_query_y;
    wire rtr_pkg::rtr_coord_t  calibrated_x, calibrated_y;
    wire rtr_pkg::rtr_sample_t direct_x, direct_y;
    wire rtr_pkg::rtr_sample_t first_resistance_sample;
    wire rtr_pkg::rtr_sample_t second_resistance_sample;
    logic [33:0] exp_r [$];
    logic [1:0]  exp_b [$];
    int          err_count = 0, n_checks = 0;
    integer      seed = 32'h5BC31533;
    logic        t;
    logic [15:0] p;
    rtr_pkg::rtr_sample_t dx, dy, z1, z2;
    rtr_pkg::rtr_coord_t  cx, cy;
    localparam logic [11:0] offs [6] = '{12'h120, 12'h124, 12'h128,
                                         12'h12C, 12'h18C, 12'h190};
    localparam logic [31:0] rstv [6] = '{32'h00007FFF, 32'h80008000,
                                         32'h0, 32'h0, 32'h0, 32'h0};

    rtr_result_regs DUT (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sample_valid, .touch_sensed,
        .direct_x, .direct_y, .first_resistance_sample,
        .second_resistance_sample, .calibrated_x, .calibrated_y,
        .frame_done, .tag_result, .tag_query_x, .tag_query_y, .irq);
    rtr_panel_model panel (.aclk, .go, .set_in, .sample_valid, .touch_sensed,
        .direct_x, .direct_y, .first_resistance_sample,
        .second_resistance_sample, .calibrated_x, .calibrated_y);

    // 125 MHz system clock
    initial forever #4 aclk = ~aclk;

    task check(input logic [33:0] seen, input logic [33:0] want,
               input string nm);
        n_checks++;
        if (seen !== want)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, want, seen);
        end
    endtask : check

    task final_report;
        if (err_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    // readiness is looked at on the falling edge, where it has settled
    task rd(input logic [11:0] a, input logic [31:0] d,
            input logic [1:0] r = 2'h0);
        logic h;
        @(posedge aclk);
        exp_r.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin @(negedge aclk); h = s_axi_arready; @(posedge aclk); end
        while (!h);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge aclk); h = s_axi_rvalid; @(posedge aclk); end
        while (!h);
        s_axi_rready <= 1'b0;
    endtask : rd

    task wr(input logic [11:0] a, input logic [31:0] d,
            input logic [1:0] r = 2'h0);
        logic pa, pw, ha, hw;
        @(posedge aclk);
        exp_b.push_back(r);
        {pa, pw} = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ha = pa && s_axi_awready;
            hw = pw && s_axi_wready;
            @(posedge aclk);
            if (ha) begin s_axi_awvalid <= 1'b0; pa = 1'b0; end
            if (hw) begin s_axi_wvalid <= 1'b0; pw = 1'b0; end
        end
        while (pa || pw);
        do begin @(negedge aclk); ha = s_axi_bvalid; @(posedge aclk); end
        while (!ha);
        s_axi_bready <= 1'b0;
    endtask : wr

    // one random sample set, then a frame end with a fresh tag
    task samp;
        @(posedge aclk);
        t = 1'($random(seed));
        {dx, dy, z1, z2} = 40'({$random(seed), $random(seed)});
        {cx, cy} = $random(seed);
        tg = 8'($random(seed)) | 8'h01;
        set_in <= {t, dx, dy, z1, z2, cx, cy};
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (2) @(posedge aclk);
        frame_done <= 1'b1;
        tag_result <= tg;
        @(posedge aclk);
        frame_done <= 1'b0;
        tag_result <= ~tg; // the held tag must not follow the display
    endtask : samp

    // answers are compared in order of request
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front(),
                  "rdata");
        if (s_axi_bvalid && s_axi_bready)
            check({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()},
                  "bresp");
    end

    // main sequence
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(offs[i], rstv[i]);
        rd(12'h300, 32'h0, 2'h2);
        wr(12'h300, 32'h1, 2'h2);
        repeat (8)
        begin
            samp;
            p = t ? ((z2 > z1) ? 16'(z2 - z1) << 5 : 16'h0) : 16'h7FFF;
            rd(12'h124, t ? {cx, cy} : 32'h80008000);
            rd(12'h18C,
               {~t, 5'h0, dx, 6'h0, dy});
            rd(12'h190, {6'h0, z1, 6'h0, z2});
            rd(12'h120, {16'h0, p});
            rd(12'h12C, t ? {24'h0, tg} : 32'h0);
            rd(12'h128, t ? {cx, cy} : 32'h80008000);
            wr(12'h124, ~{cx, cy});
            rd(12'h124, t ? {cx, cy} : 32'h80008000);
        end
        check(34'(irq), 34'h0, "irq"); // pending status, enable still off
        wr(12'h204, 32'h8);
        @(negedge aclk);
        check(34'(irq), 34'h1, "irq");
        rd(12'h204, 32'h8);
        wr(12'h208, 32'hF);
        @(negedge aclk);
        check(34'(irq), 34'h0, "irq");
        rd(12'h200, 32'h0);
        repeat (4) @(posedge aclk);
        final_report;
    end

    // watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        #100000;
        err_count++;
        final_report;
    end
endmodule : testbench
